/* File: common/pt_pkg.sv */
// Shared constants, types and helpers of the periodic timer.
package pt_pkg;

  ////////////////////////////////////////////////////////////////////
  // Widths and reset values.
  localparam int        PT_CNT_W     = 10;      // Counter width.
  localparam logic [9:0] PT_CNT_MAX  = 10'h3ff; // Counter top value.
  localparam logic [7:0] PT_BYTE_RST = 8'h00;   // Control byte reset.
  localparam logic [9:0] PT_CMP_RST  = 10'h000; // Compare value reset.

  ////////////////////////////////////////////////////////////////////
  // Register byte addresses on the bus.
  localparam logic [7:0] PT_OFS_CTRL0  = 8'h00; // Clock select, on.
  localparam logic [7:0] PT_OFS_CTRL1  = 8'h04; // Mode and pin setup.
  localparam logic [7:0] PT_OFS_CNT_LO = 8'h08; // Counter bits 7..0.
  localparam logic [7:0] PT_OFS_CNT_HI = 8'h0c; // Counter bits 9..8.
  localparam logic [7:0] PT_OFS_CMPA_LO = 8'h10; // Compare A low.
  localparam logic [7:0] PT_OFS_CMPA_HI = 8'h14; // Compare A high.
  localparam logic [7:0] PT_OFS_CMPP_LO = 8'h18; // Compare P low.
  localparam logic [7:0] PT_OFS_CMPP_HI = 8'h1c; // Compare P high.
  localparam logic [7:0] PT_OFS_FLAGS  = 8'h20; // Match flags, W1C.

  ////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int PT_ON_BIT    = 3; // Counter on control in CTRL0.
  localparam int PT_CKSEL_LSB = 4; // Clock select, three bits.
  localparam int PT_MODE_LSB  = 6; // Mode select, two bits.
  localparam int PT_PIO_LSB   = 4; // Pin function, two bits.
  localparam int PT_OC_BIT    = 3; // Output initial level.
  localparam int PT_POL_BIT   = 2; // Output invert.
  localparam int PT_CCLR_BIT  = 0; // Counter clear select.
  localparam int PT_FA_BIT    = 0; // Match A flag.
  localparam int PT_FP_BIT    = 1; // Match P flag.

  ////////////////////////////////////////////////////////////////////
  // Operating modes.
  typedef enum logic [1:0] {
    PT_MODE_CMP   = 2'b00,
    PT_MODE_UNDEF = 2'b01,
    PT_MODE_PWM   = 2'b10,
    PT_MODE_TC    = 2'b11
  } pt_mode_e;

  // Pin function codes; meaning depends on the mode.
  localparam logic [1:0] PT_PIO_00 = 2'b00; // Hold / force inactive.
  localparam logic [1:0] PT_PIO_01 = 2'b01; // Low / force active.
  localparam logic [1:0] PT_PIO_10 = 2'b10; // High / PWM output.
  localparam logic [1:0] PT_PIO_11 = 2'b11; // Toggle / single pulse.

  // Counter clock sources.
  typedef enum logic [2:0] {
    PT_CK_DIV4   = 3'b000,
    PT_CK_DIV1   = 3'b001,
    PT_CK_DIV16  = 3'b010,
    PT_CK_DIV64  = 3'b011,
    PT_CK_SLOW_A = 3'b100,
    PT_CK_SLOW_B = 3'b101,
    PT_CK_EXT_R  = 3'b110,
    PT_CK_EXT_F  = 3'b111
  } pt_cksel_e;

  // High byte of a 10-bit value; upper bits read as zero.
  function automatic logic [7:0] pt_hi_byte(input logic [9:0] v);
    pt_hi_byte = {6'h00, v[9:8]};
  endfunction : pt_hi_byte

endpackage : pt_pkg

/* File: src/pt_sync.sv */
// Two flip-flop synchroniser for the external clock pin.
`timescale 1ns/1ps
module pt_sync
  import pt_pkg::*;
(
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Asynchronous level in, synchronised level out.
  input  wire logic async_i,
  output logic      sync_o
);

  // Both stages in one struct; only stage two is read outside.
  typedef struct packed {
    logic s1; // First stage, read by the second stage only.
    logic s2; // Second stage, safe to use.
  } pt_sync_s;

  pt_sync_s s_reg;
  pt_sync_s s_next;

  // Shift the pin through the two stages.
  always_comb
  begin
    s_next.s1 = async_i;
    s_next.s2 = s_reg.s1;
  end

  // Register the stages.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign sync_o = s_reg.s2;

endmodule : pt_sync

/* File: src/pt_prescale.sv */
// Counter clock tick generator for the periodic timer.
`timescale 1ns/1ps
module pt_prescale
  import pt_pkg::*;
#(
  parameter int SLOW_DIV_W = 8 // Slow source is clk divided by 2**this.
)
(
  // Clock and reset.
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  // Source select and synchronised pin edges.
  input  wire pt_cksel_e sel_i,
  input  wire logic      ext_rise_i,
  input  wire logic      ext_fall_i,
  // One-cycle tick per counter clock.
  output logic           tick_o
);

  // Free running divider; the divided sources tap its wrap points, both slow sources the same one.
  typedef struct packed {
    logic [SLOW_DIV_W-1:0] div; // Divider count.
  } pt_pre_s;

  pt_pre_s s_reg;
  pt_pre_s s_next;

  // Advance the divider on every clock.
  always_comb
  begin
    s_next.div = s_reg.div + 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // Pick the tick; pin edges arrive already synchronised.
  always_comb
  begin
    unique case (sel_i)
      PT_CK_DIV4:   tick_o = &s_reg.div[1:0];
      PT_CK_DIV1:   tick_o = 1'b1;
      PT_CK_DIV16:  tick_o = &s_reg.div[3:0];
      PT_CK_DIV64:  tick_o = &s_reg.div[5:0];
      PT_CK_SLOW_A: tick_o = &s_reg.div;
      PT_CK_SLOW_B: tick_o = &s_reg.div;
      PT_CK_EXT_R:  tick_o = ext_rise_i;
      PT_CK_EXT_F:  tick_o = ext_fall_i;
    endcase
  end

endmodule : pt_prescale

/* File: src/pt_timer.sv */
// Ten-bit periodic timer with two comparators and a Wishbone slave.
//
// Notes on behaviour
// (R1) Mode 00 selects compare-match output.
// (R2) Clear select low: P match clears, flags both.
// (R3) Clear select high: A match clears, no P flag.
// (R4) Compare A zero: run to 3FF, no A flag.
// (R5) Compare mode: only A match moves pin.
// (R6) A match sets, clears, toggles or holds pin.
// (R7) Counter on rising edge loads initial level.
// (R8) Mode 11 counts like compare, pin undriven.
// (R9) Software picks mode 10, function 10 for PWM.
// (R10) PWM: P match sets period, A duty.
// (R11) Period is P, or 1024 when P zero.
// (R12) Duty A at or above period: always active.
// (R13) PWM raises A and P flags on matches.
// (R14) PWM functions 00/01 force level; level, invert apply.
// (R15) Software picks function 11, keeps it, for pulse.
// (R16) On rise starts pulse; pin edge sets on.
// (R17) A match or software clear ends the pulse.
// (R18) Pulse: counter zeroed only by on rise.
// (R19) Compare values split into low and high byte.
// (R20) Compare functions 01/10/11: low, high, toggle.
// (R21) On rise zeroes counter; on fall holds it.
// (R22) Each compare checked once per counter clock.
//
// The implementer's own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module pt_timer
  import pt_pkg::*;
#(
  parameter int SLOW_DIV_W = 8 // Divider width of the slow sources.
)
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Classic Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // External clock or trigger pin, asynchronous.
  input  wire logic        external_clock_pin_i,
  // Timer output pin.
  output logic             timer_pin_o,
  output logic             timer_pin_oe_o
);

  ////////////////////////////////////////////////////////////////////
  // State of the block, kept in one record.
  typedef struct packed {
    logic [9:0]  cnt;        // Counter.
    logic [9:0]  cmp_a;      // Compare value A.
    logic [9:0]  cmp_p;      // Compare value P.
    pt_cksel_e   cksel;      // Counter clock source.
    logic        on;         // Counter on control.
    logic        on_d;       // On control one cycle ago.
    pt_mode_e    mode;       // Operating mode.
    logic [1:0]  pio;        // Pin function select.
    logic        oc;         // Output initial level.
    logic        pol;        // Output invert.
    logic        cclr;       // Counter clear select.
    logic        flag_a;     // Match A flag.
    logic        flag_p;     // Match P flag.
    logic        cmp_lvl;    // Compare mode pin level.
    logic        ext_d;      // Synchronised pin one cycle ago.
    logic        pin;        // Registered pin level.
    logic        pin_oe;     // Registered pin enable.
    logic        ack;        // Bus acknowledge.
    logic [7:0]  rdata;      // Bus read data.
  } pt_state_s;

  pt_state_s s_reg;
  pt_state_s s_next;

  ////////////////////////////////////////////////////////////////////
  // Pin synchroniser and counter clock generation.

  logic ext_sync; // Pin level after two flops.
  logic ext_rise; // Rising edge of the synchronised pin.
  logic ext_fall; // Falling edge of the synchronised pin.
  logic tick;     // One counter clock.

  pt_sync u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (external_clock_pin_i),
    .sync_o  (ext_sync)
  );

  // Edges look at the second stage and its delayed copy only.
  assign ext_rise = ext_sync & ~s_reg.ext_d;
  assign ext_fall = ~ext_sync & s_reg.ext_d;

  pt_prescale #(
    .SLOW_DIV_W (SLOW_DIV_W)
  ) u_pre (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .sel_i      (s_reg.cksel),
    .ext_rise_i (ext_rise),
    .ext_fall_i (ext_fall),
    .tick_o     (tick)
  );

  ////////////////////////////////////////////////////////////////////
  // Comparators and clear decisions.

  logic [9:0] cnt_inc;   // Counter plus one.
  logic       top;       // Counter at its maximum.
  logic       hit_a;     // Counter reaches compare A.
  logic       hit_p;     // Counter reaches compare P.
  logic       wrap_p;    // P match or overflow with P zero.
  logic       wrap_a;    // A match or overflow with A zero.
  logic       pulse_md;  // Single pulse mode selected.
  logic       pwm_md;    // PWM family selected.
  logic       pwm_act;   // PWM waveform in its active phase.
  logic       rise;      // Counter on rising edge.
  logic       trig_edge; // Active pin edge for the pulse trigger.

  // Full 10-bit compares against the value the counter moves to.
  always_comb
  begin
    cnt_inc  = s_reg.cnt + 10'h001;
    top      = (s_reg.cnt == PT_CNT_MAX);
    hit_a    = (s_reg.cmp_a != PT_CMP_RST) && (cnt_inc == s_reg.cmp_a); // (R22)
    hit_p    = (s_reg.cmp_p != PT_CMP_RST) && (cnt_inc == s_reg.cmp_p); // (R22)
    // A zero compare value lets the counter run to 3FF and wrap.
    wrap_p   = hit_p | ((s_reg.cmp_p == PT_CMP_RST) & top); // (R2)
    wrap_a   = hit_a | ((s_reg.cmp_a == PT_CMP_RST) & top); // (R4)
    pwm_md   = (s_reg.mode == PT_MODE_PWM);
    pulse_md = pwm_md & (s_reg.pio == PT_PIO_11);
    // Counter stays below the period, so A at or above it is 100%.
    pwm_act  = (s_reg.cnt < s_reg.cmp_a); // (R12)
    rise     = s_reg.on & ~s_reg.on_d;
    trig_edge = (s_reg.cksel == PT_CK_EXT_F) ? ext_fall : ext_rise;
  end

  ////////////////////////////////////////////////////////////////////
  // Next state: bus access, counting, flags and pin.

  logic       req;    // New bus request this cycle.
  logic       wr;     // Byte lane zero write.
  logic [7:0] wdat;   // Written byte.
  logic       clr_a;  // Software clears flag A.
  logic       clr_p;  // Software clears flag P.
  logic       set_a;  // Hardware raises flag A.
  logic       set_p;  // Hardware raises flag P.
  logic       act;    // Active phase in the PWM family.
  logic       lvl;    // Pin level before the invert.

  always_comb
  begin
    s_next = s_reg;
    s_next.ack = 1'b0;
    s_next.on_d = s_reg.on;
    s_next.ext_d = ext_sync;
    set_a = 1'b0;
    set_p = 1'b0;
    clr_a = 1'b0;
    clr_p = 1'b0;
    act = 1'b0;
    lvl = 1'b0;

    // A request is taken once; ack drops in the following cycle.
    req  = wb_cyc_i & wb_stb_i & ~s_reg.ack;
    wr   = req & wb_we_i & wb_sel_i[0];
    wdat = wb_dat_i[7:0];

    // Register writes; the counter is read only.
    if (wr)
    begin
      unique case (wb_adr_i)
        PT_OFS_CTRL0:
        begin
          s_next.cksel = pt_cksel_e'(wdat[PT_CKSEL_LSB +: 3]);
          s_next.on    = wdat[PT_ON_BIT];
        end
        PT_OFS_CTRL1:
        begin
          s_next.mode = pt_mode_e'(wdat[PT_MODE_LSB +: 2]);
          s_next.pio  = wdat[PT_PIO_LSB +: 2];
          s_next.oc   = wdat[PT_OC_BIT];
          s_next.pol  = wdat[PT_POL_BIT];
          s_next.cclr = wdat[PT_CCLR_BIT];
        end
        PT_OFS_CMPA_LO: s_next.cmp_a[7:0] = wdat;        // (R19)
        PT_OFS_CMPA_HI: s_next.cmp_a[9:8] = wdat[1:0];   // (R19)
        PT_OFS_CMPP_LO: s_next.cmp_p[7:0] = wdat;        // (R19)
        PT_OFS_CMPP_HI: s_next.cmp_p[9:8] = wdat[1:0];   // (R19)
        PT_OFS_FLAGS:
        begin
          clr_a = wdat[PT_FA_BIT];
          clr_p = wdat[PT_FP_BIT];
        end
        default: ;
      endcase
    end

    // Read data is latched with the ack; unmapped reads give zero.
    if (req)
    begin
      s_next.ack = 1'b1;
      unique case (wb_adr_i)
        PT_OFS_CTRL0:
          s_next.rdata = {1'b0, s_reg.cksel, s_reg.on, 3'h0};
        PT_OFS_CTRL1:
          s_next.rdata = {s_reg.mode, s_reg.pio, s_reg.oc, s_reg.pol,
                          1'b0, s_reg.cclr};
        PT_OFS_CNT_LO:  s_next.rdata = s_reg.cnt[7:0];
        PT_OFS_CNT_HI:  s_next.rdata = pt_hi_byte(s_reg.cnt);
        PT_OFS_CMPA_LO: s_next.rdata = s_reg.cmp_a[7:0];
        PT_OFS_CMPA_HI: s_next.rdata = pt_hi_byte(s_reg.cmp_a); // (R19)
        PT_OFS_CMPP_LO: s_next.rdata = s_reg.cmp_p[7:0];
        PT_OFS_CMPP_HI: s_next.rdata = pt_hi_byte(s_reg.cmp_p); // (R19)
        PT_OFS_FLAGS:
          s_next.rdata = {6'h00, s_reg.flag_p, s_reg.flag_a};
        default:        s_next.rdata = 8'h00;
      endcase
    end

    // Start of a run: zero the counter and load the initial level.
    if (rise)
    begin
      s_next.cnt     = PT_CMP_RST;  // (R21) (R18)
      s_next.cmp_lvl = s_reg.oc;    // (R7)
    end
    // A counter that is off holds its value.
    else if (s_reg.on && tick)
    begin
      if (pulse_md)
      begin
        // Never cleared here; it only stops at the top value.
        if (!top)
          s_next.cnt = cnt_inc; // (R18)
        if (hit_a)
        begin
          set_a = 1'b1;         // (R17)
          s_next.on = 1'b0;     // (R17)
        end
      end
      else if (pwm_md)
      begin
        // Clear select is ignored; P alone sets the period.
        s_next.cnt = wrap_p ? PT_CMP_RST : cnt_inc; // (R10) (R11)
        set_a = hit_a;  // (R13)
        set_p = wrap_p; // (R13)
      end
      else if (s_reg.cclr)
      begin
        // A match clears; P flag is never raised here.
        s_next.cnt = wrap_a ? PT_CMP_RST : cnt_inc; // (R3) (R4)
        set_a = hit_a;                              // (R3)
      end
      else
      begin
        // P match or overflow clears; both flags follow matches.
        s_next.cnt = wrap_p ? PT_CMP_RST : cnt_inc; // (R2)
        set_a = hit_a; // (R2) (R4)
        set_p = wrap_p; // (R2)
      end

      // Compare mode pin follows the A flag only, never P.
      if (set_a && s_reg.mode == PT_MODE_CMP) // (R1) (R5)
      begin
        unique case (s_reg.pio)
          PT_PIO_00: s_next.cmp_lvl = s_reg.cmp_lvl;  // (R6)
          PT_PIO_01: s_next.cmp_lvl = 1'b0;           // (R20)
          PT_PIO_10: s_next.cmp_lvl = 1'b1;           // (R20)
          PT_PIO_11: s_next.cmp_lvl = ~s_reg.cmp_lvl; // (R20)
        endcase
      end
    end

    // Pin edge sets the on control in pulse mode; start wins.
    if (pulse_md && trig_edge && !s_reg.on)
      s_next.on = 1'b1; // (R16)

    // A new event wins over a clear in the same cycle.
    s_next.flag_a = (s_reg.flag_a & ~clr_a) | set_a;
    s_next.flag_p = (s_reg.flag_p & ~clr_p) | set_p;

    // Pin level per mode; the timer mode leaves the pin free.
    unique case (s_reg.mode)
      PT_MODE_CMP:
      begin
        lvl = s_reg.cmp_lvl; // (R1)
        s_next.pin_oe = 1'b1;
      end
      PT_MODE_PWM:
      begin
        unique case (s_reg.pio)
          PT_PIO_00: act = 1'b0;    // (R14)
          PT_PIO_01: act = 1'b1;    // (R14)
          PT_PIO_10: act = pwm_act; // (R10) (R12)
          PT_PIO_11: act = s_reg.on; // (R16) (R17)
        endcase
        // Initial level bit names the active level.
        lvl = act ? s_reg.oc : ~s_reg.oc; // (R14)
        s_next.pin_oe = 1'b1;
      end
      PT_MODE_UNDEF,
      PT_MODE_TC:
      begin
        lvl = 1'b0;
        s_next.pin_oe = 1'b0; // (R8)
      end
    endcase
    s_next.pin = lvl ^ s_reg.pol; // (R14)
  end

  ////////////////////////////////////////////////////////////////////
  // State register with synchronous reset.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_reg       <= '0;
      s_reg.cmp_a <= PT_CMP_RST;
      s_reg.cmp_p <= PT_CMP_RST;
      s_reg.cksel <= PT_CK_DIV4;
      s_reg.mode  <= PT_MODE_CMP;
      s_reg.rdata <= PT_BYTE_RST;
      s_reg.pin_oe <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register.
  assign wb_ack_o       = s_reg.ack;
  assign wb_dat_o       = {24'h000000, s_reg.rdata};
  assign timer_pin_o    = s_reg.pin;
  assign timer_pin_oe_o = s_reg.pin_oe;

endmodule : pt_timer

/* File: testbench/pt_sva.sv */
// Assertion checker bound to the periodic timer top module.
`timescale 1ns/1ps
module pt_sva
#(
  parameter int SLOW_DIV_W = 8 // Slow divider width, kept for the bind.
)
(
  // Clock and reset.
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Wishbone slave port.
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Timer output pin.
  input wire logic        timer_pin_o,
  input wire logic        timer_pin_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic       take_w; // A write request taken at this edge.
  logic [7:0] c1_q;   // Last mode and pin setup written.
  logic       on_q;   // Last counter on value written.
  logic [2:0] age_q;  // Clocks since a control write, saturating.

  assign take_w = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;

  // Shadow of the control bytes; age lets the pin settle first.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      c1_q  <= 8'h00;
      on_q  <= 1'b0;
      age_q <= 3'h0;
    end
    else
    begin
      if (take_w && wb_adr_i == 8'h04)
        c1_q <= wb_dat_i[7:0];
      if (take_w && wb_adr_i == 8'h00)
        on_q <= wb_dat_i[3];
      if (take_w && (wb_adr_i == 8'h04 || wb_adr_i == 8'h00))
        age_q <= 3'h0;
      else if (age_q != 3'h7)
        age_q <= age_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  dat_hi_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper lanes not zero");
  rst_out_a: assert property ($fell(rst_i) |-> !wb_ack_o && !timer_pin_o && timer_pin_oe_o)
    else $error("outputs wrong after reset");
  hi_byte_a: assert property (wb_ack_o && !wb_we_i && (wb_adr_i == 8'h14 || wb_adr_i == 8'h1c)
    |-> wb_dat_o[7:2] == 6'h00) else $error("high byte upper bits set");
  oe_drive_a: assert property (age_q == 3'h7 && c1_q[7:6] == 2'b00 |-> timer_pin_oe_o)
    else $error("pin not driven in compare mode");
  oe_free_a: assert property (age_q == 3'h7 && c1_q[7:6] == 2'b11 |-> !timer_pin_oe_o)
    else $error("pin driven in timer mode");
  pwm_force_a: assert property (age_q == 3'h7 && on_q && c1_q[7:5] == 3'b100
    |-> timer_pin_o == ~^c1_q[4:2]) else $error("forced pwm level wrong");
  hold_pin_a: assert property (age_q == 3'h7 && c1_q[7:4] == 4'h0 |=> $stable(timer_pin_o))
    else $error("pin moved with no pin function");
  init_lvl_a: assert property (take_w && wb_adr_i == 8'h00 && wb_dat_i[3] && !on_q
    && c1_q[7:6] == 2'b00 |-> ##[1:4] timer_pin_o == (c1_q[3] ^ c1_q[2]))
    else $error("initial level not loaded");
endmodule : pt_sva

bind pt_timer pt_sva #(.SLOW_DIV_W(SLOW_DIV_W)) u_sva (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .timer_pin_o(timer_pin_o), .timer_pin_oe_o(timer_pin_oe_o));

/* File: testbench/pt_pin_model.sv */
// Behavioural model of the trigger pin source and the output load.
`timescale 1ns/1ps
module pt_pin_model
#(
  parameter int HALF = 6 // Clocks per half period; raise it for a slow source.
)
(
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Burst request from the bench.
  input  wire logic       go_i,
  input  wire logic [7:0] edges_i,
  // Pin into the timer, and the load on its output.
  input  wire logic       load_i,
  output logic            ext_pin_o,
  output logic            busy_o,
  output int              load_rises_o
);
  int   left;   // Pin changes still to make.
  int   ph;     // Clocks spent in this half period.
  logic load_q; // Load level one clock ago.

  assign busy_o = (left != 0);

  // The line idles low between bursts, as if pulled down; each rising
  // edge either triggers a single pulse or clocks the counter.
  always_ff @(posedge clk_i)
  begin
    load_q <= load_i;
    if (rst_i)
    begin
      left         <= 0;
      ph           <= 0;
      ext_pin_o    <= 1'b0;
      load_rises_o <= 0;
    end
    else
    begin
      if (load_i && !load_q)
        load_rises_o <= load_rises_o + 1;
      if (go_i && left == 0)
        left <= 2 * int'(edges_i);
      else if (left != 0 && ph == HALF - 1)
      begin
        ph        <= 0;
        ext_pin_o <= ~ext_pin_o;
        left      <= left - 1;
      end
      else if (left != 0)
        ph <= ph + 1;
    end
  end
endmodule : pt_pin_model

/* File: testbench/tb_pt_timer.sv */
// Self-checking bench of the periodic timer.
`timescale 1ns/1ps
module tb_pt_timer;
  logic        clk_i = 1'b0, rst_i = 1'b1, go = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00, n_edges = 8'h00, q, q2;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic        wb_ack_o, ext_pin, pin_o, pin_oe, pm_busy;
  int          rises, err_count = 0, n_compared = 0;

  always #12.5 clk_i = ~clk_i;

  pt_timer #(.SLOW_DIV_W(6)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .external_clock_pin_i(ext_pin), .timer_pin_o(pin_o), .timer_pin_oe_o(pin_oe));
  pt_pin_model #(.HALF(6)) u_pm (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .edges_i(n_edges),
    .load_i(pin_o), .ext_pin_o(ext_pin), .busy_o(pm_busy), .load_rises_o(rises));

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("BAD %s exp %0h seen %0h", nm, exp, seen);
      err_count++;
    end
  endtask : chk

  // One classic cycle; the request is held until ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 40);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
    if (n >= 40)
    begin
      err_count++;
      stop_test();
    end
  endtask : wb

  task automatic setcmp(input logic [9:0] a, input logic [9:0] p);
    wb(1'b1, 8'h10, a[7:0]);
    wb(1'b1, 8'h14, {6'h00, a[9:8]});
    wb(1'b1, 8'h18, p[7:0]);
    wb(1'b1, 8'h1c, {6'h00, p[9:8]});
  endtask : setcmp

  // Setup changes only while stopped, then c0 is written, which switches the counter on if its bit 3 is set.
  task automatic run(input logic [7:0] c1, input logic [7:0] c0);
    wb(1'b1, 8'h00, c0 & 8'hf7);
    wb(1'b1, 8'h04, c1);
    wb(1'b1, 8'h20, 8'h03);
    wb(1'b1, 8'h00, c0);
    repeat (2) @(posedge clk_i);
  endtask : run

  task automatic cnt_act(input int n, input logic lvl, output int c);
    c = 0;
    repeat (n)
    begin
      @(posedge clk_i);
      if (pin_o === lvl)
        c++;
    end
  endtask : cnt_act

  initial
  begin
    logic [7:0] ra[4] = '{8'h14, 8'h1c, 8'h18, 8'h20};
    logic [7:0] fq[$] = '{8'ha8, 8'ha1, 8'ha8, 8'hac, 8'ha8, 8'h88, 8'h94};
    int pq[$] = '{4, 7, 5, 3, 0, 6, 6};
    int aq[$] = '{1, 3, 5, 9, 256, 2, 2};
    int n, per, ex, r0;
    void'($urandom(29988));
    repeat (3)
    begin
      pq.push_back(2 + $urandom % 40);
      aq.push_back(1 + $urandom % (pq[$] + 2));
      fq.push_back({4'ha, 2'($urandom), 1'b0, 1'($urandom)});
    end
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Reset values, high byte masking, flag clear and an unmapped place.
    foreach (ra[i])
    begin
      wb(1'b0, ra[i], 8'h00);
      chk("reg_rst", q, 8'h00);
      wb(1'b1, ra[i], 8'hff);
      wb(1'b0, ra[i], 8'h00);
      chk("reg_rw", q, (i < 2) ? 8'h03 : (i == 2) ? 8'hff : 8'h00);
    end
    wb(1'b1, 8'h3c, 8'hff);
    wb(1'b0, 8'h3c, 8'h00);
    chk("unmapped", q, 8'h00);
    $display("test regs done");
    // Compare mode, every pin function, initial level opposite to it.
    setcmp(10'd8, 10'd12);
    for (int pio = 0; pio < 4; pio++)
    begin
      ex = (pio == 2) ? 0 : 1;
      run({2'b00, 2'(pio), ex[0], 3'b000}, 8'h18);
      chk("init_lvl", pin_o, ex);
      repeat (30) @(posedge clk_i);
      q2 = {7'h0, pin_o};
      repeat (12) @(posedge clk_i);
      chk("cmp_pin", pin_o, (pio == 3) ? !q2[0] : (pio != 1));
      wb(1'b0, 8'h20, 8'h00);
      chk("cmp_flags", q, 8'h03);
    end
    $display("test compare done");
    run(8'hc0, 8'h18);
    repeat (40) @(posedge clk_i);
    wb(1'b0, 8'h20, 8'h00);
    chk("tc_flags", q, 8'h03);
    chk("tc_oe", pin_oe, 1'b0);
    setcmp(10'd8, 10'd3);
    run(8'h19, 8'h18);
    repeat (40) @(posedge clk_i);
    wb(1'b0, 8'h20, 8'h00);
    chk("clr_a_flags", q, 8'h01);
    chk("clr_a_pin", pin_o, 1'b0);
    setcmp(10'd0, 10'd0);
    run(8'h18, 8'h18);
    repeat (1100) @(posedge clk_i);
    wb(1'b0, 8'h20, 8'h00);
    chk("ovf_flags", q, 8'h02);
    chk("ovf_pin", pin_o, 1'b1);
    $display("test modes done");
    // PWM: active cycles over one period against the duty model.
    foreach (pq[i])
    begin
      setcmp(10'(aq[i]), 10'(pq[i]));
      run(fq[i], 8'h18);
      per = (pq[i] == 0) ? 1024 : pq[i];
      ex = (fq[i][5:4] == 2'b10) ? ((aq[i] < per) ? aq[i] : per) : (fq[i][4] ? per : 0);
      repeat (per + 4) @(posedge clk_i);
      cnt_act(per, fq[i][3] ^ fq[i][2], n);
      chk("pwm_duty", n, ex);
      wb(1'b0, 8'h20, 8'h00);
      chk("pwm_flags", q, (aq[i] <= per) ? 8'h03 : 8'h02);
    end
    $display("test pwm done");
    // Single pulse ended by software; period compare must not clear.
    setcmp(10'd200, 10'd5);
    run(8'hb8, 8'h18);
    chk("sp_lead", pin_o, 1'b1);
    repeat (20) @(posedge clk_i);
    wb(1'b1, 8'h00, 8'h10);
    repeat (2) @(posedge clk_i);
    chk("sp_trail", pin_o, 1'b0);
    wb(1'b0, 8'h08, 8'h00);
    q2 = q;
    chk("sp_count", q2 > 8'd5, 1'b1);
    repeat (10) @(posedge clk_i);
    wb(1'b0, 8'h08, 8'h00);
    chk("sp_hold", q, q2);
    // Single pulse triggered and clocked by the pin, ended by a match.
    setcmp(10'd3, 10'd0);
    run(8'hb8, 8'h60);
    r0 = rises;
    n_edges <= 8'd4;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    for (n = 0; n < 400 && (pm_busy || n < 2); n++)
      @(posedge clk_i);
    if (n >= 400)
      err_count++;
    repeat (8) @(posedge clk_i);
    wb(1'b0, 8'h00, 8'h00);
    chk("sp_on_clr", q, 8'h60);
    wb(1'b0, 8'h20, 8'h00);
    chk("sp_flag", q[0], 1'b1);
    chk("sp_pin", pin_o, 1'b0);
    chk("sp_once", rises - r0, 1);
    $display("test pulse done");
    stop_test();
  end
endmodule : tb_pt_timer
